// ### design/smx_cmd_exec.sv
// Command trigger executor: latches command writes, starts sampling and streams replies.
// Assumes a same-clock frame handler, converter and link transmitter; no input synchronisers.
`timescale 1ns/1ns
module smx_cmd_exec
  import smx_pkg::*;
(
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire smx_wr_s wr, // Decoded register byte write from a frame.
  input wire logic frame_end, // One-cycle pulse after the last byte of a frame.
  input wire logic [7:0] reg_rd_addr, // Register read address.
  output logic [7:0] reg_rd_data, // Register read data, one cycle later.
  input wire logic [4:0] dev_addr, // This device's link address.
  input wire logic turn_go, // Pulse: preceding devices have replied.
  output logic last_responder, // This reply ends a group sequence.
  output logic smp_start, // One-cycle pulse: start synchronous sampling.
  output logic [31:0] smp_mask, // Channels for the current command.
  output logic [7:0] smp_avg, // Averaging setting for the current command.
  input wire logic smp_busy, // Converter is sampling, manual or periodic.
  input wire logic smp_done, // Pulse: requested sampling finished.
  output logic rd_req, // Request one stored sample.
  output logic [5:0] rd_idx, // Sample index; 32 is the ground value.
  input wire logic rd_ack, // Sample data valid, request taken.
  input wire logic [15:0] rd_data, // Sample value.
  output logic tx_valid, // Reply byte present.
  output smx_byte_s tx_byte, // Reply byte and end-of-reply mark.
  input wire logic tx_ready, // Link takes the reply byte.
  output logic busy // A command is executing.
);

  typedef struct packed {
    smx_state_e st;
    logic [31:0] chan;
    logic [7:0] avg;
    logic fcmd_seen;
    smx_job_s fjob;
    logic pend_valid;
    smx_job_s pend;
    smx_job_s cur;
    logic [31:0] scan;
    logic gnd_pend;
    logic rd_req;
    logic [5:0] rd_idx;
    logic [7:0] lo_byte;
    logic start;
    logic [31:0] smask;
    logic last_resp;
    logic [7:0] rdata;
    logic tx_v;
    smx_byte_s tx_d;
    logic busy;
  } smx_exec_s;

  smx_exec_s s_r;
  smx_exec_s s_nxt;
  logic buf_ready;
  logic push;
  logic [4:0] top;
  logic grouped;

  // Highest set bit of a channel mask; reply order runs from bit 31 downward.
  function automatic logic [4:0] top_bit(input logic [31:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : top_bit

  // Register byte holding a given write address inside the 32-bit channel mask.
  function automatic logic [1:0] chan_byte(input logic [7:0] a);
    return 2'(a - CHAN_ADDR_LO);
  endfunction : chan_byte

  assign push = s_r.tx_v && buf_ready;
  assign top = top_bit(s_r.scan);
  assign grouped = (s_r.cur.kind != SMX_SINGLE) && s_r.cur.resp;

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    // Registered write path; a frame's earlier writes land before its command runs.
    if (wr.valid) begin
      if (wr.addr >= CHAN_ADDR_LO && wr.addr <= CHAN_ADDR_HI) begin
        // Byte at the lowest address holds the top bits of the mask. [R5] [R17]
        s_nxt.chan[8 * (3 - chan_byte(wr.addr)) +: 8] = wr.data;
      end
      if (wr.addr == AVG_ADDR) begin
        s_nxt.avg = wr.data; // [R5]
      end
      if (wr.addr == CMD_ADDR) begin
        s_nxt.fcmd_seen = 1'b1;
        s_nxt.fjob.cmd = wr.data;
        s_nxt.fjob.resp = wr.resp;
        s_nxt.fjob.kind = wr.kind;
      end
    end
    // A command is snapshot at frame end with whatever the frame left in the registers.
    if (frame_end && s_r.fcmd_seen) begin
      // A command byte landing with the frame end stays recorded, so the set wins.
      s_nxt.fcmd_seen = wr.valid && (wr.addr == CMD_ADDR);
      s_nxt.pend_valid = 1'b1;
      s_nxt.pend = s_r.fjob;
      s_nxt.pend.chan = s_nxt.chan; // [R4] [R5]
      s_nxt.pend.avg = s_nxt.avg; // [R4] [R5]
    end
    // The stored command value is never exposed to readers. [R3]
    if (reg_rd_addr >= CHAN_ADDR_LO && reg_rd_addr <= CHAN_ADDR_HI) begin
      s_nxt.rdata = s_r.chan[8 * (3 - chan_byte(reg_rd_addr)) +: 8];
    end else if (reg_rd_addr == AVG_ADDR) begin
      s_nxt.rdata = s_r.avg;
    end else begin
      s_nxt.rdata = HIDDEN_READ; // [R3]
    end
    case (s_r.st)
      SMX_IDLE: begin
        // Pending work is only taken here, so replies never interleave. [R19]
        if (s_r.pend_valid) begin
          s_nxt.pend_valid = frame_end && s_r.fcmd_seen;
          s_nxt.cur = s_r.pend;
          s_nxt.smask = s_r.pend.chan & CHAN_VALID; // [R7]
          s_nxt.busy = 1'b1;
          if (!s_r.pend.cmd[REQUEST_TYPE_BIT_BIT]) begin
            s_nxt.start = 1'b1; // [R9]
            s_nxt.st = SMX_SAMPLE;
          end else if (s_r.pend.resp) begin
            s_nxt.st = SMX_WAIT_IDLE; // [R10]
          end else begin
            s_nxt.busy = 1'b0; // [R11]
          end
        end
      end
      SMX_SAMPLE: begin
        if (smp_done) begin
          // Without reply the samples are only stored. [R9]
          s_nxt.st = s_r.cur.resp ? SMX_GO_REPLY : SMX_IDLE;
          s_nxt.busy = s_r.cur.resp;
        end
      end
      SMX_WAIT_IDLE: begin
        // Periodic sampling of a subset may still leave two sample passes mixed. [R10] [R13]
        if (!smp_busy) begin
          s_nxt.st = SMX_GO_REPLY;
        end
      end
      SMX_GO_REPLY: begin
        s_nxt.scan = s_r.smask; // [R1] [R2]
        s_nxt.gnd_pend = 1'b0;
        s_nxt.last_resp = grouped && (dev_addr == s_r.cur.cmd[RESP_MSB:0]); // [R15]
        if (!grouped) begin
          s_nxt.st = SMX_SCAN; // [R16]
        end else if (dev_addr > s_r.cur.cmd[RESP_MSB:0]) begin
          // Beyond the highest responder: this device stays silent. [R15]
          s_nxt.st = SMX_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.st = SMX_WAIT_TURN; // [R14]
        end
      end
      SMX_WAIT_TURN: begin
        if (turn_go) begin
          s_nxt.st = SMX_SCAN; // [R14]
        end
      end
      SMX_SCAN: begin
        if (s_r.gnd_pend) begin
          s_nxt.gnd_pend = 1'b0;
          s_nxt.rd_idx = GND_IDX; // [R18]
          s_nxt.rd_req = 1'b1;
          s_nxt.st = SMX_FETCH;
        end else if (s_r.scan == 32'h0000_0000) begin
          s_nxt.st = SMX_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.last_resp = 1'b0;
        end else begin
          s_nxt.scan[top] = 1'b0; // [R6] [R7]
          s_nxt.gnd_pend = (top == REF_BIT); // [R18]
          s_nxt.rd_idx = {1'b0, top};
          s_nxt.rd_req = 1'b1;
          s_nxt.st = SMX_FETCH;
        end
      end
      SMX_FETCH: begin
        if (rd_ack) begin
          s_nxt.rd_req = 1'b0;
          s_nxt.lo_byte = rd_data[7:0];
          s_nxt.tx_v = 1'b1;
          s_nxt.tx_d = '{data: rd_data[15:8], last: 1'b0}; // [R6]
          s_nxt.st = SMX_SEND_HI;
        end
      end
      SMX_SEND_HI: begin
        if (push) begin
          s_nxt.tx_d.data = s_r.lo_byte; // [R6]
          s_nxt.tx_d.last = (s_r.scan == 32'h0000_0000) && !s_r.gnd_pend; // [R2]
          s_nxt.st = SMX_SEND_LO;
        end
      end
      SMX_SEND_LO: begin
        if (push) begin
          s_nxt.tx_v = 1'b0;
          s_nxt.st = SMX_SCAN;
        end
      end
      default: begin
        s_nxt.st = SMX_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.st <= SMX_IDLE;
      s_r.chan <= CHAN_RESET;
      s_r.avg <= AVG_RESET;
      s_r.rdata <= HIDDEN_READ;
    end else begin
      s_r <= s_nxt;
    end
  end

  smx_tx_buf #(
    .W($bits(smx_byte_s))
  ) u_buf (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(s_r.tx_v),
    .in_data(s_r.tx_d),
    .in_ready(buf_ready),
    .out_valid(tx_valid),
    .out_data(tx_byte),
    .out_ready(tx_ready)
  );

  assign reg_rd_data = s_r.rdata;
  assign last_responder = s_r.last_resp;
  assign smp_start = s_r.start;
  assign smp_mask = s_r.smask;
  assign smp_avg = s_r.cur.avg;
  assign rd_req = s_r.rd_req;
  assign rd_idx = s_r.rd_idx;
  assign busy = s_r.busy;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence take_job_s;
    s_r.st == SMX_IDLE && s_r.pend_valid;
  endsequence

  sequence read_only_job_s;
    take_job_s ##0 s_r.pend.cmd[REQUEST_TYPE_BIT_BIT] && !s_r.pend.resp;
  endsequence

  // The index register keeps the last fetched channel until the next request rises.
  sequence ref_then_req_s;
    $rose(rd_req) && $past(rd_idx) == {1'b0, REF_BIT};
  endsequence

  sequence fetch_open_s;
    rd_req && !rd_ack;
  endsequence

  sequence byte_held_s;
    s_r.tx_v && !buf_ready;
  endsequence

  sample_start_a: assert property ( // [R9]
    take_job_s ##0 !s_r.pend.cmd[REQUEST_TYPE_BIT_BIT] |=> smp_start ##1 !smp_start)
    else $error("sampling start not a single pulse after a sample command");

  no_action_a: assert property ( // [R11]
    read_only_job_s |=> s_r.st == SMX_IDLE && !smp_start && !busy)
    else $error("read request without reply caused activity");

  wait_idle_a: assert property ( // [R10]
    s_r.st == SMX_WAIT_IDLE && smp_busy |=> s_r.st == SMX_WAIT_IDLE)
    else $error("reply started while sampling was running");

  hidden_read_a: assert property ( // [R3]
    reg_rd_addr == CMD_ADDR |=> reg_rd_data == HIDDEN_READ)
    else $error("command register value leaked on read");

  ground_next_a: assert property ( // [R18]
    ref_then_req_s |-> rd_idx == GND_IDX)
    else $error("ground value did not follow the reference value");

  masked_only_a: assert property ( // [R7]
    rd_req && rd_idx != GND_IDX |-> s_r.smask[rd_idx[4:0]])
    else $error("value fetched for an unselected channel");

  high_first_a: assert property ( // [R6]
    s_r.st == SMX_SEND_HI && push |=> s_r.tx_d.data == $past(s_r.lo_byte))
    else $error("low byte did not follow the high byte");

  avg_write_a: assert property ( // [R5]
    frame_end && s_r.fcmd_seen && !wr.valid |=>
      s_r.pend.avg == $past(s_r.avg) && s_r.pend.chan == $past(s_r.chan))
    else $error("frame write not applied before its command");

  top_responder_a: assert property ( // [R15]
    s_r.st == SMX_WAIT_TURN |-> dev_addr <= s_r.cur.cmd[RESP_MSB:0])
    else $error("device above the responder address waits to reply");

  single_ignore_a: assert property ( // [R16]
    s_r.st == SMX_GO_REPLY && !grouped |=> s_r.st == SMX_SCAN)
    else $error("responder field used for a single request");

  no_interleave_a: assert property ( // [R19]
    s_r.st != SMX_IDLE && s_r.pend_valid |=> s_r.pend_valid)
    else $error("pending command dropped during a reply");

  // Both internal handshakes must hold still; a dropped request would lose a value.
  fetch_hold_a: assert property ( // [R6]
    fetch_open_s |=> rd_req && $stable(rd_idx))
    else $error("sample request dropped before it was answered");

  byte_hold_a: assert property ( // [R6]
    byte_held_s |=> s_r.tx_v && $stable(s_r.tx_d))
    else $error("reply byte changed while the buffer was full");

  last_byte_a: assert property ( // [R2]
    s_r.tx_v && s_r.tx_d.last |-> s_r.st == SMX_SEND_LO)
    else $error("end of reply marked on a byte other than a low byte");

  silent_above_a: assert property ( // [R15]
    s_r.st == SMX_GO_REPLY && grouped && dev_addr > s_r.cur.cmd[RESP_MSB:0] |=>
      s_r.st == SMX_IDLE && !busy)
    else $error("device above the responder address did not stay silent");

  reply_end_a: assert property ( // [R15]
    s_r.st == SMX_SCAN && s_r.scan == 32'h0000_0000 && !s_r.gnd_pend |=>
      !last_responder && !busy)
    else $error("reply end did not release the job and the last responder mark");

endmodule : smx_cmd_exec

// ### design/smx_pkg.sv
// Constants, carriers and state types for the sample command executor.
// Assumes one 100 MHz clock and a frame handler on the same clock feeding decoded writes.
// Function
// (R1) A with-reply command write returns command results, not stored register contents.
// (R2) Reply length follows the set channel selection bits; some bits give two values.
// (R3) The command trigger register cannot be read back; reads give an undefined value.
// (R4) A command without channel or averaging writes uses the values already held.
// (R5) Channel and averaging writes earlier in the same frame apply before execution.
// (R6) Values go most significant byte first, from the top mask bit downward.
// (R7) A channel whose selection bit is clear contributes no value.
// (R8) The host writes zeros into command bits seven and six.
// (R9) Request bit clear samples synchronously; with reply returns samples, without only stores.
// (R10) Request bit set with reply returns samples after any running sampling finishes.
// (R11) Request bit set without reply causes no action at all.
// (R12) The host should stop periodic sampling before issuing a sampling command.
// (R13) Partial periodic sampling may make a read-back reply mix two sample passes.
// (R14) Broadcast or group with-reply commands get replies in successive address order.
// (R15) The responder field names the highest device that must reply.
// (R16) The responder field is ignored for all other transaction types.
// (R17) Cell voltage select bits run from bit 16, lowest cell, to bit 31.
// (R18) The reference channel returns two values: reference level, then ground.
// (R19) A command arriving during a reply is processed only after that reply ends.
package smx_pkg;

  localparam logic [7:0] CMD_ADDR = 8'h02;
  localparam logic [7:0] CHAN_ADDR_LO = 8'h03;
  localparam logic [7:0] CHAN_ADDR_HI = 8'h06;
  localparam logic [7:0] AVG_ADDR = 8'h07;
  localparam logic [31:0] CHAN_RESET = 32'h0000_0000;
  localparam logic [7:0] AVG_RESET = 8'h00;
  localparam logic [7:0] HIDDEN_READ = 8'h00;
  // Bits 4 and 3 are reserved and never produce a value.
  localparam logic [31:0] CHAN_VALID = 32'hFFFF_FFE7;
  localparam int CELL_LSB = 16;
  localparam int REQUEST_TYPE_BIT_BIT = 5;
  localparam int RESP_MSB = 4;
  localparam logic [4:0] REF_BIT = 5'h02;
  localparam logic [5:0] GND_IDX = 6'h20;

  typedef enum logic [1:0] {
    SMX_SINGLE = 2'b00,
    SMX_GROUP = 2'b01,
    SMX_BCAST = 2'b10
  } smx_kind_e;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
    logic resp;
    smx_kind_e kind;
  } smx_wr_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } smx_byte_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic resp;
    smx_kind_e kind;
    logic [31:0] chan;
    logic [7:0] avg;
  } smx_job_s;

  typedef enum logic [3:0] {
    SMX_IDLE = 4'b0000,
    SMX_SAMPLE = 4'b0001,
    SMX_WAIT_IDLE = 4'b0010,
    SMX_GO_REPLY = 4'b0011,
    SMX_WAIT_TURN = 4'b0100,
    SMX_SCAN = 4'b0101,
    SMX_FETCH = 4'b0110,
    SMX_SEND_HI = 4'b0111,
    SMX_SEND_LO = 4'b1000
  } smx_state_e;

endpackage : smx_pkg

// ### design/smx_tx_buf.sv
// Two-entry reply byte buffer with valid and ready on both sides.
// Assumes the filler and the drainer share the module clock.
`timescale 1ns/1ns
module smx_tx_buf
  import smx_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic sys_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic in_valid, // Filler offers a word.
  input wire logic [W-1:0] in_data, // Offered word.
  output logic in_ready, // Buffer has room.
  output logic out_valid, // Head word present.
  output logic [W-1:0] out_data, // Head word.
  input wire logic out_ready // Drainer takes the head word.
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
  } smx_buf_s;

  smx_buf_s s_r;
  smx_buf_s s_nxt;
  logic push;
  logic pop;

  assign push = in_valid && s_r.rdy;
  assign pop = s_r.vld && out_ready;
  assign in_ready = s_r.rdy;
  assign out_valid = s_r.vld;
  assign out_data = s_r.head;

  always_comb begin
    s_nxt = s_r;
    if (push && pop) begin
      if (s_r.cnt == 2'h1) begin
        s_nxt.head = in_data;
      end else begin
        s_nxt.head = s_r.tail;
        s_nxt.tail = in_data;
      end
    end else if (pop) begin
      s_nxt.head = s_r.tail;
      s_nxt.cnt = s_r.cnt - 2'h1;
    end else if (push) begin
      if (s_r.cnt == 2'h0) begin
        s_nxt.head = in_data;
      end else begin
        s_nxt.tail = in_data;
      end
      s_nxt.cnt = s_r.cnt + 2'h1;
    end
    s_nxt.vld = (s_nxt.cnt != 2'h0);
    s_nxt.rdy = (s_nxt.cnt != 2'h2);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= '{head: '0, tail: '0, cnt: 2'h0, vld: 1'b0, rdy: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : smx_tx_buf

// ### sim/smx_conv_model.sv
// Converter and sample store model facing the executor's sampling and read ports.
// Assumes the executor's clock; the bench sets read lag and periodic sampling activity.
`timescale 1ns/1ns
module smx_conv_model (
  input wire logic sys_clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic smp_start, // Sampling request.
  input wire logic auto_busy, // Periodic sampling running.
  input wire logic [3:0] lag, // Cycles before a read is answered.
  output logic smp_busy, // Sampling under way.
  output logic smp_done, // Requested sampling finished.
  input wire logic rd_req, // Sample read request.
  input wire logic [5:0] rd_idx, // Sample index.
  output logic rd_ack, // Read answered.
  output logic [15:0] rd_data // Sample value.
);
  logic [3:0] run_r;
  logic [3:0] wait_r;
  assign smp_busy = auto_busy || (run_r != 4'h0);
  // Outside an answer the data shows the inverse so a stale latch is caught.
  assign rd_data = rd_ack ? {8'hA5, 2'b00, rd_idx} : ~{8'hA5, 2'b00, rd_idx};
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run_r <= 4'h0;
      wait_r <= 4'h0;
      smp_done <= 1'b0;
      rd_ack <= 1'b0;
    end else begin
      smp_done <= (run_r == 4'h1);
      run_r <= smp_start ? 4'h6 : (run_r != 4'h0 ? run_r - 4'h1 : 4'h0);
      rd_ack <= rd_req && !rd_ack && (wait_r >= lag);
      wait_r <= (rd_req && !rd_ack && wait_r < lag) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : smx_conv_model

// ### sim/tb.sv
// Self-checking bench for the sample command executor.
// Assumes the converter model stands on the sampling side; the bench plays frame handler and link.
`timescale 1ns/1ns
module tb;
  import smx_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  smx_wr_s wr = '0;
  logic frame_end = 1'b0;
  logic [7:0] reg_rd_addr = 8'h00;
  logic [4:0] dev_addr = 5'h05;
  logic turn_go = 1'b0;
  logic tx_ready = 1'b1;
  logic stall = 1'b0;
  logic auto_busy = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] reg_rd_data, smp_avg;
  logic [31:0] smp_mask, start_mask;
  logic last_responder, smp_start, smp_busy, smp_done, rd_req, rd_ack, tx_valid, busy;
  logic [5:0] rd_idx;
  logic [15:0] rd_data;
  smx_byte_s tx_byte;
  logic [8:0] got[$];
  logic [8:0] exp[$];
  int starts = 0;
  int bad_count = 0;
  int check_count = 0;
  always #5 sys_clk = ~sys_clk;
  smx_cmd_exec DUT (.sys_clk(sys_clk), .srst(srst), .wr(wr), .frame_end(frame_end),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .dev_addr(dev_addr),
    .turn_go(turn_go), .last_responder(last_responder), .smp_start(smp_start),
    .smp_mask(smp_mask), .smp_avg(smp_avg), .smp_busy(smp_busy), .smp_done(smp_done),
    .rd_req(rd_req), .rd_idx(rd_idx), .rd_ack(rd_ack), .rd_data(rd_data),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .busy(busy));
  smx_conv_model conv (.sys_clk(sys_clk), .srst(srst), .smp_start(smp_start),
    .auto_busy(auto_busy), .lag(lag), .smp_busy(smp_busy), .smp_done(smp_done),
    .rd_req(rd_req), .rd_idx(rd_idx), .rd_ack(rd_ack), .rd_data(rd_data));
  always @(negedge sys_clk) tx_ready <= stall ? ~tx_ready : 1'b1;
  always @(posedge sys_clk) begin
    if (!srst && tx_valid && tx_ready) got.push_back({tx_byte.data, tx_byte.last});
    if (!srst && smp_start) begin
      starts++;
      start_mask = smp_mask;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic r, input smx_kind_e k);
    @(negedge sys_clk);
    wr <= '{1'b1, a, d, r, k};
    @(negedge sys_clk);
    wr.valid <= 1'b0;
  endtask : put
  // One frame: optional channel and averaging writes, then the command, then the frame end.
  task automatic frame(input logic [31:0] m, input logic [7:0] cmd, input logic r,
                       input smx_kind_e k, input logic wm);
    if (wm) begin
      for (int i = 0; i < 4; i++) put(8'(CHAN_ADDR_LO + i), m[31 - 8 * i -: 8], r, k);
      put(AVG_ADDR, 8'h5A, r, k);
    end
    put(CMD_ADDR, cmd, r, k);
    @(negedge sys_clk);
    frame_end <= 1'b1;
    @(negedge sys_clk);
    frame_end <= 1'b0;
  endtask : frame
  task automatic expect_vals(input logic [31:0] m);
    for (int b = 31; b >= 0; b--) begin
      if (m[b] && CHAN_VALID[b]) begin
        exp.push_back({8'hA5, 1'b0});
        exp.push_back({2'b00, 6'(b), 1'b0});
        if (b == 2) begin
          exp.push_back({8'hA5, 1'b0});
          exp.push_back({2'b00, GND_IDX, 1'b0});
        end
      end
    end
    exp[$][0] = 1'b1;
  endtask : expect_vals
  task automatic collect();
    int i;
    i = 0;
    while (got.size() < exp.size() && i < 2000) begin
      @(negedge sys_clk);
      i++;
    end
    if (got.size() < exp.size()) begin
      bad_count++;
      conclude();
    end
    repeat (10) @(negedge sys_clk);
    check("reply_len", got.size(), exp.size());
    foreach (exp[k]) if (k < got.size()) check("reply_byte", got[k], exp[k]);
    got.delete();
    exp.delete();
  endtask : collect
  task automatic idle_check(input string what, input int n, input logic busy_want);
    int b;
    b = 0;
    repeat (n) begin
      @(negedge sys_clk);
      b = b | busy;
    end
    check(what, got.size(), 0);
    check({what, "_busy"}, b, busy_want);
  endtask : idle_check
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(negedge sys_clk);
    reg_rd_addr <= a;
    @(negedge sys_clk);
    check("reg_read", reg_rd_data, want);
  endtask : rd
  task automatic t_sample();
    stall = 1'b1;
    frame(32'h8001_0015, 8'h00, 1'b1, SMX_SINGLE, 1'b1);
    expect_vals(32'h8001_0015);
    collect();
    check("start_count", starts, 1);
    check("start_mask", start_mask, 32'h8001_0005);
    check("avg", smp_avg, 8'h5A);
    rd(8'h03, 8'h80);
    rd(AVG_ADDR, 8'h5A);
    stall = 1'b0;
    $display("test sample done");
  endtask : t_sample
  task automatic t_read();
    auto_busy = 1'b1;
    lag = 4'h3;
    frame(32'h0, 8'h20, 1'b1, SMX_SINGLE, 1'b0);
    idle_check("early_reply", 30, 1'b1);
    // Periodic sampling stays off for every later sampling command.
    auto_busy = 1'b0;
    expect_vals(32'h8001_0015);
    collect();
    check("no_start", starts, 1);
    rd(CMD_ADDR, HIDDEN_READ);
    lag = 4'h0;
    $display("test read done");
  endtask : t_read
  task automatic t_silent();
    frame(32'h0, 8'h20, 1'b0, SMX_SINGLE, 1'b0);
    idle_check("quiet_reply", 20, 1'b0);
    check("quiet_start", starts, 1);
    frame(32'h0, 8'h00, 1'b0, SMX_SINGLE, 1'b0);
    idle_check("store_reply", 40, 1'b1);
    check("store_start", starts, 2);
    $display("test silent done");
  endtask : t_silent
  task automatic t_group();
    smx_kind_e kinds[2];
    kinds = '{SMX_GROUP, SMX_BCAST};
    frame(32'h0, 8'h24, 1'b1, SMX_GROUP, 1'b0);
    idle_check("below_reply", 40, 1'b1);
    check("below_busy", busy, 1'b0);
    for (int j = 0; j < 2; j++) begin
      frame(32'h0, 8'h25 + 8'(2 * j), 1'b1, kinds[j], 1'b0);
      idle_check("turn_reply", 20, 1'b1);
      check("last_resp", last_responder, j == 0);
      @(negedge sys_clk);
      turn_go <= 1'b1;
      @(negedge sys_clk);
      turn_go <= 1'b0;
      expect_vals(32'h8001_0015);
      collect();
    end
    $display("test group done");
  endtask : t_group
  task automatic t_queue();
    int i;
    i = 0;
    // A slow sample store keeps the first reply running while the second frame lands.
    lag = 4'h6;
    frame(32'h8001_0000, 8'h00, 1'b1, SMX_SINGLE, 1'b1);
    while (got.size() == 0 && i < 500) begin
      @(negedge sys_clk);
      i++;
    end
    if (got.size() == 0) begin
      bad_count++;
      conclude();
    end
    frame(32'h0, 8'h20, 1'b1, SMX_SINGLE, 1'b0);
    check("queue_overlap", busy, 1'b1);
    expect_vals(32'h8001_0000);
    expect_vals(32'h8001_0000);
    collect();
    lag = 4'h0;
    $display("test queue done");
  endtask : t_queue
  initial begin
    repeat (12) @(negedge sys_clk);
    srst <= 1'b0;
    rd(8'h03, 8'h00);
    t_sample();
    t_read();
    t_silent();
    t_group();
    t_queue();
    conclude();
  end
endmodule : tb
